// ### src/ebs_pkg.sv
package ebs_pkg;

  // register byte addresses
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_CTRL    = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'hC;

  // status register field positions
  localparam int BIT_IN_FRAME = 7;
  localparam int BIT_STRICT   = 6;
  localparam int BIT_SPARE_A  = 3;
  localparam int BIT_ALARM    = 2;
  localparam int BIT_SPARE_B  = 1;
  localparam int BIT_SPARE_C  = 0;

  // control register fields
  localparam int CTRL_CRIT_LSB = 0;
  localparam int CTRL_CAS      = 2;

  // interrupt bits
  localparam int IRQ_LOF_CHG   = 0;
  localparam int IRQ_CRC_LOSS  = 1;
  localparam int IRQ_ALARM_CHG = 2;

  localparam logic [1:0] CRIT_ACTIVE = 2'h3;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // timing
  localparam int CLK_HZ = 250000000;
  localparam int WINDOW_S = 1;
  localparam int WINDOW_CYCLES = CLK_HZ * WINDOW_S;
  localparam int ERR_LIMIT = 915;
  localparam int MFA_RUN_LIMIT = 4;

  localparam int TS16_BIT_LSB = 0;

  typedef struct packed {
    logic       frame_start;
    logic       mf_frame0;
    logic       ts16_valid;
    logic [7:0] ts16_byte;
    logic       in_frame;
    logic       crc_err;
    logic       mfa_err;
  } ebs_line_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } ebs_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } ebs_av_rsp_t;

endpackage

// ### src/ebs_err_window.sv
`timescale 1ns/1ns
`default_nettype none
// counts crc errors over a fixed one-second window, restarted at each window end
module ebs_err_window #(
  parameter int WINDOW = ebs_pkg::WINDOW_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic crc_err,
  output logic      over_limit
);

  typedef struct packed {
    logic [27:0] tick;
    logic [15:0] errs;
    logic        over;
  } ebs_win_t;

  ebs_win_t st;
  ebs_win_t next_st;

  always_comb begin
    next_st = st;
    if (!enable) begin
      next_st = '0;
    end else if (st.tick == 28'(WINDOW - 1)) begin
      next_st.tick = '0;
      next_st.errs = 16'(crc_err);
    end else begin
      next_st.tick = st.tick + 28'h0000001;
      if (crc_err && st.errs != 16'hFFFF) begin
        next_st.errs = st.errs + 16'h0001;
      end
    end
    next_st.over = enable && (next_st.errs >= 16'(ebs_pkg::ERR_LIMIT));
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign over_limit = st.over;

endmodule
`default_nettype wire

// ### src/ebs_ts16_capture.sv
`timescale 1ns/1ns
`default_nettype none
// captures timeslot 16 bits of frame 0 once per multiframe
module ebs_ts16_capture (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       mf_frame0,
  input  wire logic       ts16_valid,
  input  wire logic [7:0] ts16_byte,
  output logic      [3:0] extra
);

  typedef struct packed {
    logic [3:0] bits;
  } ebs_cap_t;

  ebs_cap_t st;
  ebs_cap_t next_st;

  always_comb begin
    next_st = st;
    if (mf_frame0 && ts16_valid) begin
      // bits 5..8 of the slot, bit 1 being msb
      next_st.bits = ts16_byte[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign extra = st.bits;

  capture_hold_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !($past(mf_frame0) && $past(ts16_valid)) |-> $stable(extra))
    else $error("extra bits changed outside frame 0");

endmodule
`default_nettype wire

// ### src/ebs_top.sv
// Contract
// - status bit 7 reads 1 in frame, 0 under frame loss; resets 0.
// - strict select 0, criteria 11: loss on 915 crc errors per second.
// - strict select 1, criteria 11: also loss on 4 errored alignments.
// - status bit 3 holds slot 16 bit 5 of multiframe frame 0.
// - status bit 2 holds slot 16 bit 6, the multiframe remote alarm.
// - status bit 1 holds slot 16 bit 7 of multiframe frame 0.
// - status bit 0 holds slot 16 bit 8 of multiframe frame 0.
`timescale 1ns/1ns
`default_nettype none
module ebs_top #(
  parameter int WINDOW = ebs_pkg::WINDOW_CYCLES
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire ebs_pkg::ebs_line_t   line,
  input  wire ebs_pkg::ebs_av_req_t av_req,
  output var  ebs_pkg::ebs_av_rsp_t av_rsp,
  output logic                      crc_mf_loss,
  output logic                      irq
);

  typedef struct packed {
    logic        in_frame;
    logic        strict_sel;
    logic [1:0]  criteria;
    logic        cas;
    logic [2:0]  mfa_run;
    logic        crc_loss;
    logic [2:0]  irq_st;
    logic [2:0]  irq_msk;
    logic        ack;
    logic [31:0] rdata;
  } ebs_state_t;

  ebs_state_t st;
  ebs_state_t next_st;
  logic [3:0] extra;
  logic       over_limit;
  logic [7:0] status;
  logic       criteria_on;
  logic [2:0] events;
  logic       loss_now;

  ebs_ts16_capture i_ebs_ts16_capture (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .mf_frame0  (line.mf_frame0),
    .ts16_valid (line.ts16_valid),
    .ts16_byte  (line.ts16_byte),
    .extra      (extra)
  );

  ebs_err_window #(.WINDOW(WINDOW)) i_ebs_err_window (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .enable     (criteria_on),
    .crc_err    (line.crc_err),
    .over_limit (over_limit)
  );

  assign criteria_on = (st.criteria == ebs_pkg::CRIT_ACTIVE);

  // loss decision
  always_comb begin
    loss_now = over_limit;
    if (st.strict_sel && st.mfa_run >= 3'(ebs_pkg::MFA_RUN_LIMIT)) begin
      loss_now = 1'b1;
    end
    loss_now = loss_now && criteria_on;
  end

  // status image: reserved bits 5..4 zero
  always_comb begin
    status = ebs_pkg::STATUS_RESET;
    status[ebs_pkg::BIT_IN_FRAME] = st.in_frame;
    status[ebs_pkg::BIT_STRICT]   = st.strict_sel;
    status[ebs_pkg::BIT_SPARE_A]  = extra[3];
    status[ebs_pkg::BIT_ALARM]    = extra[2];
    status[ebs_pkg::BIT_SPARE_B]  = extra[1];
    status[ebs_pkg::BIT_SPARE_C]  = extra[0];
  end

  always_comb begin
    events = '0;
    events[ebs_pkg::IRQ_LOF_CHG]   = st.in_frame != line.in_frame;
    events[ebs_pkg::IRQ_CRC_LOSS]  = loss_now && !st.crc_loss;
    events[ebs_pkg::IRQ_ALARM_CHG] = line.mf_frame0 && line.ts16_valid &&
      (line.ts16_byte[2] != extra[2]) && st.cas;
  end

  always_comb begin
    next_st = st;
    next_st.in_frame = line.in_frame;
    if (!criteria_on) begin
      next_st.mfa_run = '0;
    end else if (line.mfa_err) begin
      if (st.mfa_run != 3'h7) begin
        next_st.mfa_run = st.mfa_run + 3'h1;
      end
    end else if (line.mf_frame0 && line.frame_start) begin
      next_st.mfa_run = '0;
    end
    next_st.crc_loss = loss_now;
    next_st.ack = 1'b0;
    next_st.rdata = '0;
    if ((av_req.read || av_req.write) && !st.ack) begin
      next_st.ack = 1'b1;
    end
    // software clear first, so hardware set wins
    if (av_req.write && !st.ack &&
        av_req.address == ebs_pkg::ADDR_IRQ_ST) begin
      next_st.irq_st = st.irq_st & ~av_req.writedata[2:0];
    end
    next_st.irq_st = next_st.irq_st | events;
    if (av_req.write && !st.ack) begin
      unique case (av_req.address)
        ebs_pkg::ADDR_STATUS: begin
          next_st.strict_sel = av_req.writedata[ebs_pkg::BIT_STRICT];
        end
        ebs_pkg::ADDR_CTRL: begin
          next_st.criteria = av_req.writedata[ebs_pkg::CTRL_CRIT_LSB +: 2];
          next_st.cas      = av_req.writedata[ebs_pkg::CTRL_CAS];
        end
        ebs_pkg::ADDR_IRQ_MSK: begin
          next_st.irq_msk = av_req.writedata[2:0];
        end
        default: begin
        end
      endcase
    end
    // reads change only ack and rdata
    if (av_req.read && !st.ack) begin
      unique case (av_req.address)
        ebs_pkg::ADDR_STATUS:  next_st.rdata = {24'h000000, status};
        ebs_pkg::ADDR_CTRL:    next_st.rdata = {29'h0, st.cas, st.criteria};
        ebs_pkg::ADDR_IRQ_ST:  next_st.rdata = {29'h0, st.irq_st};
        ebs_pkg::ADDR_IRQ_MSK: next_st.rdata = {29'h0, st.irq_msk};
        default:               next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign av_rsp.waitrequest = (av_req.read || av_req.write) && !st.ack;
  assign av_rsp.readdata    = st.rdata;
  assign crc_mf_loss        = st.crc_loss;
  assign irq                = |(st.irq_st & st.irq_msk);

  in_frame_track_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    reset_n |=> status[ebs_pkg::BIT_IN_FRAME] == $past(line.in_frame))
    else $error("in-frame bit does not follow framer");

  lenient_crit_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!st.strict_sel && !over_limit) |=> !crc_mf_loss)
    else $error("loss declared without error count");

  window_loss_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (criteria_on && over_limit) |=> crc_mf_loss)
    else $error("error count did not declare loss");

  criteria_gate_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !criteria_on |=> !crc_mf_loss)
    else $error("loss declared with criteria off");

  loss_irq_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (loss_now && !crc_mf_loss) |=> st.irq_st[ebs_pkg::IRQ_CRC_LOSS])
    else $error("loss event not latched");

  strict_run_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (criteria_on && st.strict_sel &&
     st.mfa_run >= 3'(ebs_pkg::MFA_RUN_LIMIT)) |=> crc_mf_loss)
    else $error("four errored alignments missed");

  spare_map_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (line.mf_frame0 && line.ts16_valid) |=>
      status[3:0] == $past(line.ts16_byte[3:0]))
    else $error("slot bits not captured");

  alarm_bit_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (line.mf_frame0 && line.ts16_valid && st.cas &&
     line.ts16_byte[2] != status[ebs_pkg::BIT_ALARM]) |=>
      st.irq_st[ebs_pkg::IRQ_ALARM_CHG])
    else $error("alarm change not latched");

  reserved_zero_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (av_req.read && !st.ack && av_req.address == ebs_pkg::ADDR_STATUS) |=>
      av_rsp.readdata[5:4] == 2'h0)
    else $error("reserved bits nonzero");

  status_read_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (av_req.read && !st.ack && av_req.address == ebs_pkg::ADDR_STATUS) |=>
      av_rsp.readdata == {24'h000000, $past(status)})
    else $error("status read data wrong");

  read_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (av_req.read && !av_req.write) |=>
      st.irq_msk == $past(st.irq_msk) && st.criteria == $past(st.criteria))
    else $error("read changed state");

  bus_answer_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (av_req.read && av_rsp.waitrequest) |=> !av_rsp.waitrequest)
    else $error("bus answer late");

endmodule
`default_nettype wire

// ### tb/ebs_line_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-end line source: frame state, slot 16 bytes, error pulses
module ebs_line_model (
  input  wire logic          ref_clk,
  output var ebs_pkg::ebs_line_t line
);
  initial line = '0;
  task automatic set_frame(input logic v);
    @(posedge ref_clk);
    line.in_frame <= v;
  endtask
  // slot 16 byte valid for one cycle, inverted once released
  task automatic send_ts16(input logic [7:0] b, input logic f0);
    @(posedge ref_clk);
    line.frame_start <= 1'b1;
    line.mf_frame0   <= f0;
    line.ts16_valid  <= 1'b1;
    line.ts16_byte   <= b;
    @(posedge ref_clk);
    line.frame_start <= 1'b0;
    line.mf_frame0   <= 1'b0;
    line.ts16_valid  <= 1'b0;
    line.ts16_byte   <= ~b;
  endtask
  // n error pulses on consecutive edges
  task automatic send_errs(input int n, input logic mfa);
    if (n > 0) begin
      @(posedge ref_clk);
      if (mfa) line.mfa_err <= 1'b1;
      else line.crc_err <= 1'b1;
      repeat (n) @(posedge ref_clk);
      line.mfa_err <= 1'b0;
      line.crc_err <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/test_ebs_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_ebs_top;
  logic                 ref_clk;
  logic                 reset_n;
  ebs_pkg::ebs_line_t   line;
  ebs_pkg::ebs_av_req_t av_req;
  ebs_pkg::ebs_av_rsp_t av_rsp;
  logic                 crc_mf_loss;
  logic                 irq;
  logic [31:0]          q;
  int                   bad_count;
  int                   tests_run;

  ebs_top #(.WINDOW(2000)) i_ebs_top (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .line        (line),
    .av_req      (av_req),
    .av_rsp      (av_rsp),
    .crc_mf_loss (crc_mf_loss),
    .irq         (irq)
  );
  ebs_line_model i_ebs_line_model (
    .ref_clk (ref_clk),
    .line    (line)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic [3:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge ref_clk);
    av_req <= '{a, ~w, w, d};
    do @(posedge ref_clk);
    while (av_rsp.waitrequest !== 1'b0);
    q = av_rsp.readdata;
    av_req <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    acc(a, 1'b1, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    acc(a, 1'b0, 32'h0);
    chk(q, e);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask

  // loss criteria case: strict, criteria, crc errors, mfa errors
  task automatic loss(input logic s, input logic [1:0] c,
                      input int nc, input int nm, input logic e);
    do_reset();
    wr(ebs_pkg::ADDR_CTRL, {30'h0, c});
    wr(ebs_pkg::ADDR_STATUS, {25'h0, s, 6'h0});
    wr(ebs_pkg::ADDR_IRQ_MSK, 32'h2);
    i_ebs_line_model.send_errs(nc, 1'b0);
    i_ebs_line_model.send_errs(nm, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, crc_mf_loss}, {31'h0, e});
    chk({31'h0, irq}, {31'h0, e});
    rd(ebs_pkg::ADDR_IRQ_ST, {30'h0, e, 1'b0});
    wr(ebs_pkg::ADDR_IRQ_MSK, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  initial begin
    reset_n = 1'b0;
    av_req  = '0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(ebs_pkg::ADDR_STATUS, 32'h0);
    rd(ebs_pkg::ADDR_CTRL, 32'h0);
    rd(ebs_pkg::ADDR_IRQ_ST, 32'h0);
    rd(ebs_pkg::ADDR_IRQ_MSK, 32'h0);
    rd(4'h2, 32'h0);
    i_ebs_line_model.set_frame(1'b1);
    repeat (3) @(posedge ref_clk);
    rd(ebs_pkg::ADDR_STATUS, 32'h80);
    rd(ebs_pkg::ADDR_IRQ_ST, 32'h1);
    wr(ebs_pkg::ADDR_IRQ_ST, 32'h1);
    rd(ebs_pkg::ADDR_IRQ_ST, 32'h0);
    i_ebs_line_model.set_frame(1'b0);
    repeat (3) @(posedge ref_clk);
    rd(ebs_pkg::ADDR_STATUS, 32'h0);
    // software reads slot bits with signalling in use
    wr(ebs_pkg::ADDR_CTRL, 32'h4);
    i_ebs_line_model.send_ts16(8'hF5, 1'b1);
    rd(ebs_pkg::ADDR_STATUS, 32'h5);
    rd(ebs_pkg::ADDR_STATUS, 32'h5);
    i_ebs_line_model.send_ts16(8'h0A, 1'b0);
    rd(ebs_pkg::ADDR_STATUS, 32'h5);
    i_ebs_line_model.send_ts16(8'h3A, 1'b1);
    rd(ebs_pkg::ADDR_STATUS, 32'hA);
    wr(ebs_pkg::ADDR_STATUS, 32'h40);
    rd(ebs_pkg::ADDR_STATUS, 32'h4A);
    rd(ebs_pkg::ADDR_IRQ_ST, 32'h5);
    loss(1'b0, 2'h3, 914, 0, 1'b0);
    loss(1'b0, 2'h3, 915, 0, 1'b1);
    loss(1'b0, 2'h2, 915, 0, 1'b0);
    loss(1'b0, 2'h3, 0, 4, 1'b0);
    loss(1'b1, 2'h3, 0, 3, 1'b0);
    loss(1'b1, 2'h3, 0, 4, 1'b1);
    loss(1'b1, 2'h3, 915, 0, 1'b1);
    loss(1'b1, 2'h1, 0, 4, 1'b0);
    final_report();
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
